// ### gps_pkg.sv
// Constants for the global pulse-select and identification register bank.
// Assumes a host parallel register port with an 8-bit address, 8-bit data, and
// single-cycle read and write strobes in the clk domain.
// Operation
// - Bit 0 at 0xF4 enables custom pulse generators, effective only in E1 mode.
// - Setting the enable puts every E1-mode channel of the 14 into custom mode together.
// - In custom mode each channel shapes from its own shape registers 8..F.
// - Enable cleared at reset; standard E1 template used on all E1-mode channels.
// - Read-only 8-bit part identifier at offset 0xFE.
// - Read-only 8-bit silicon revision at offset 0xFF, hard-wired per revision.
package gps_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] GPS_OFS_SHAPE_SEL = 8'hF4;
  localparam logic [7:0] GPS_OFS_PART_ID   = 8'hFE;
  localparam logic [7:0] GPS_OFS_REVISION  = 8'hFF;
  localparam int         GPS_ENABLE_BIT    = 0;
  localparam logic       GPS_ENABLE_RESET  = 1'h0;
  localparam logic [7:0] GPS_RDATA_RESET   = 8'h00;
  // ----------------------------------------------------------------
  // Channel structure
  // ----------------------------------------------------------------
  localparam int         GPS_NUM_CH        = 14;
  localparam logic [3:0] GPS_SHAPE_FIRST   = 4'h8;
  localparam logic [3:0] GPS_SHAPE_LAST    = 4'hF;
endpackage : gps_pkg

// ### gps_ch_mode.sv
// Per-channel pulse-shape source selector.
// Assumes the global enable and the channel's E1 mode come from registered state.
`timescale 1ns/1ps
`default_nettype none
module gps_ch_mode (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic global_en,
  input  wire logic ch_e1_mode,
  output logic      custom_shape_ff
);
  import gps_pkg::*;

  typedef struct packed {
    logic custom;
  } gps_ch_state_t;

  gps_ch_state_t st_ff;
  gps_ch_state_t nxt_st;

  // ----------------------------------------------------------------
  // Source select
  // ----------------------------------------------------------------
  // Custom shaping only applies to a channel running E1; T1/J1 keep their own templates.
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.custom = global_en & ch_e1_mode;
  end

  // State register; reset selects the standard template.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{custom: GPS_ENABLE_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign custom_shape_ff = st_ff.custom;
endmodule : gps_ch_mode
`default_nettype wire

// ### gps_regs.sv
// Global pulse-select and identification register bank, top level.
// Assumes host strobes are one-cycle pulses synchronous to clk; read data
// appears on the edge after the read strobe and holds until the next read.
// Assumes each channel's E1 mode select is a steady level from that channel's setup.
`timescale 1ns/1ps
`default_nettype none
// Identity values are parameters, so a new silicon revision only changes the instance.
module gps_regs #(
  parameter logic [7:0] PART_ID  = 8'h5A, // Arbitrary neutral value.
  parameter logic [7:0] REVISION = 8'h03  // Arbitrary neutral value.
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [7:0]                 host_addr,
  input  wire logic [7:0]                 host_wdata,
  input  wire logic                       host_wr,
  input  wire logic                       host_rd,
  input  wire logic [gps_pkg::GPS_NUM_CH-1:0] ch_e1_mode,
  output logic      [7:0]                 host_rdata,
  output logic                            e1_custom_shape_enable,
  output logic      [gps_pkg::GPS_NUM_CH-1:0] ch_custom_shape
);
  import gps_pkg::*;

  // Read data is held in state so the read port shows a flop, not the address decode.
  typedef struct packed {
    logic       enable;
    logic [7:0] rdata;
  } gps_state_t;

  gps_state_t st_ff;
  gps_state_t nxt_st;

  // Channel selects gathered on a net, so that each instance owns exactly one bit.
  wire logic [GPS_NUM_CH-1:0] ch_shape_sel;

  // Select-register hit, shared by the write path and some of the checks.
  function automatic logic sel_hit(input logic [7:0] a);
    return a == GPS_OFS_SHAPE_SEL;
  endfunction : sel_hit

  // Read decode; unmapped offsets answer zero so a probe never sees stale data.
  function automatic logic [7:0] rd_value(input logic [7:0] a, input logic en);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      GPS_OFS_SHAPE_SEL: v = {7'h00, en};
      GPS_OFS_PART_ID:   v = PART_ID;
      GPS_OFS_REVISION:  v = REVISION;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction : rd_value

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  // Only bit 0 of the select register is stored; everything else drops writes.
  // Reads use the stored bit, so a read and a write in one cycle return the old value.
  always_comb begin
    nxt_st = st_ff;
    if (host_wr && sel_hit(host_addr)) begin
      nxt_st.enable = host_wdata[GPS_ENABLE_BIT];
    end
    if (host_rd) begin
      nxt_st.rdata = rd_value(host_addr, st_ff.enable);
    end
  end

  // Single state register.
  // Reset is asynchronous, so the standard template returns even with clk stopped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{enable: GPS_ENABLE_RESET, rdata: GPS_RDATA_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign host_rdata             = st_ff.rdata;
  assign e1_custom_shape_enable = st_ff.enable;

  // ----------------------------------------------------------------
  // Channel fan-out
  // ----------------------------------------------------------------
  // One global bit drives every channel, so all switch on the same edge.
  // E1 gating sits in each channel, so T1/J1 channels never act on the enable.
  genvar gi;
  generate
    for (gi = 0; gi < GPS_NUM_CH; gi++) begin : g_ch
      gps_ch_mode u_ch (
        .clk             (clk),
        .rst_n           (rst_n),
        .global_en       (st_ff.enable),
        .ch_e1_mode      (ch_e1_mode[gi]),
        .custom_shape_ff (ch_shape_sel[gi])
      );
    end
  endgenerate

  // Each bit is a flop inside its channel; this only renames the net onto the port.
  assign ch_custom_shape = ch_shape_sel;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // All checks run on clk and are switched off while rst_n is low.
  // Write path.
  property p_write_en;
    @(posedge clk) disable iff (!rst_n)
      host_wr && host_addr == GPS_OFS_SHAPE_SEL |=> e1_custom_shape_enable == $past(host_wdata[0]);
  endproperty
  a_write_en: assert property (p_write_en) else $error("enable did not follow write");

  // Channel fan-out follows the enable and the mode with one cycle of lag.
  property p_all_ch;
    @(posedge clk) disable iff (!rst_n)
      ##1 1 |-> ch_custom_shape == ({GPS_NUM_CH{$past(e1_custom_shape_enable)}} & $past(ch_e1_mode));
  endproperty
  a_all_ch: assert property (p_all_ch) else $error("channel modes not in step");

  property p_no_t1;
    @(posedge clk) disable iff (!rst_n)
      ##1 1 |-> (ch_custom_shape & ~$past(ch_e1_mode)) == '0;
  endproperty
  a_no_t1: assert property (p_no_t1) else $error("custom shape on non-E1 channel");

  property p_std;
    @(posedge clk) disable iff (!rst_n)
      !e1_custom_shape_enable ##1 1 |-> ch_custom_shape == '0;
  endproperty
  a_std: assert property (p_std) else $error("custom shape while disabled");

  // Identity reads.
  property p_pid;
    @(posedge clk) disable iff (!rst_n)
      host_rd && host_addr == GPS_OFS_PART_ID |=> host_rdata == PART_ID;
  endproperty
  a_pid: assert property (p_pid) else $error("bad part identifier");

  property p_rev;
    @(posedge clk) disable iff (!rst_n)
      host_rd && host_addr == GPS_OFS_REVISION |=> host_rdata == REVISION;
  endproperty
  a_rev: assert property (p_rev) else $error("bad revision");

  // Reserved bits and read-only offsets.
  property p_resv;
    @(posedge clk) disable iff (!rst_n)
      host_rd && host_addr == GPS_OFS_SHAPE_SEL |=> host_rdata[7:1] == 7'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");

  property p_ro_wr;
    @(posedge clk) disable iff (!rst_n)
      host_wr && host_addr != GPS_OFS_SHAPE_SEL |=> $stable(e1_custom_shape_enable);
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("enable changed by other write");

  // Read data only moves on a read.
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !host_rd |=> $stable(host_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");

  // Select readback shows the stored bit in bit 0.
  property p_rd_sel;
    @(posedge clk) disable iff (!rst_n)
      host_rd && sel_hit(host_addr) |=> host_rdata[0] == $past(e1_custom_shape_enable);
  endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("select readback wrong");

  // Unmapped offsets read as zero.
  property p_unmapped;
    @(posedge clk) disable iff (!rst_n)
      host_rd && !sel_hit(host_addr) && host_addr != GPS_OFS_PART_ID
        && host_addr != GPS_OFS_REVISION |=> host_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_en_quiet;
    @(posedge clk) disable iff (!rst_n)
      !host_wr |=> $stable(e1_custom_shape_enable);
  endproperty
  a_en_quiet: assert property (p_en_quiet) else $error("enable moved without write");

  // A write of one reaches every E1 channel two edges after the strobe.
  property p_wr_on;
    @(posedge clk) disable iff (!rst_n)
      host_wr && sel_hit(host_addr) && host_wdata[GPS_ENABLE_BIT]
        |=> ##1 ch_custom_shape == $past(ch_e1_mode);
  endproperty
  a_wr_on: assert property (p_wr_on) else $error("channels missed the enable");

  property p_wr_off;
    @(posedge clk) disable iff (!rst_n)
      host_wr && sel_hit(host_addr) && !host_wdata[GPS_ENABLE_BIT] |=> ##1 ch_custom_shape == '0;
  endproperty
  a_wr_off: assert property (p_wr_off) else $error("channels kept custom shape");

  // Per-channel edges: a channel only switches when its own inputs call for it.
  generate
    for (gi = 0; gi < GPS_NUM_CH; gi++) begin : g_ch_chk
      property p_ch_rise;
        @(posedge clk) disable iff (!rst_n)
          $rose(ch_custom_shape[gi]) |-> $past(e1_custom_shape_enable) && $past(ch_e1_mode[gi]);
      endproperty
      a_ch_rise: assert property (p_ch_rise) else $error("channel switched on alone");

      property p_ch_fall;
        @(posedge clk) disable iff (!rst_n)
          $fell(ch_custom_shape[gi])
            |-> !($past(e1_custom_shape_enable) && $past(ch_e1_mode[gi]));
      endproperty
      a_ch_fall: assert property (p_ch_fall) else $error("channel switched off alone");

      property p_ch_hold;
        @(posedge clk) disable iff (!rst_n)
          $stable(e1_custom_shape_enable) && $stable(ch_e1_mode[gi]) ##1 1
            |-> $stable(ch_custom_shape[gi]);
      endproperty
      a_ch_hold: assert property (p_ch_hold) else $error("channel source moved alone");
    end
  endgenerate

  // Covers: enable rising, all channels custom, a mixed set, an identity read.

  c_enable: cover property (@(posedge clk) disable iff (!rst_n) $rose(e1_custom_shape_enable));
  c_all:    cover property (@(posedge clk) disable iff (!rst_n) &ch_custom_shape);
  c_mixed:  cover property (@(posedge clk) disable iff (!rst_n)
                            ch_custom_shape != '0 && !(&ch_custom_shape));
  c_pid:    cover property (@(posedge clk) disable iff (!rst_n)
                            host_rd && host_addr == GPS_OFS_PART_ID);
endmodule : gps_regs
`default_nettype wire

// ### gps_host.sv
// Host model that drives the register port of the bank.
// Assumes one clock; lines change only on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module gps_host (
  input  wire logic       clk,
  input  wire logic [7:0] host_rdata,
  output logic      [7:0] host_addr,
  output logic      [7:0] host_wdata,
  output logic            host_wr,
  output logic            host_rd
);
  // Quiet bus at time zero.
  initial begin
    host_addr = 8'h00;
    host_wdata = 8'h00;
    host_wr = 1'h0;
    host_rd = 1'h0;
  end

  // One strobe for exactly one rising edge; read data is taken a cycle later.
  // Idle address and data lines invert, so a design that samples them off-strobe is caught.
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk);
    host_addr = a;
    host_wdata = d;
    host_wr = w;
    host_rd = !w;
    @(negedge clk);
    q = host_rdata;
    host_wr = 1'h0;
    host_rd = 1'h0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask : xfer
endmodule : gps_host
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the pulse-select and identity register bank.
// Assumes gps_pkg, gps_regs and the gps_host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gps_pkg::*;
  localparam logic [7:0] PID = 8'hC3; // Arbitrary value.
  localparam logic [7:0] REV = 8'h07; // Arbitrary value.
  logic                  clk = 1'h0;
  logic                  rst_n = 1'h0;
  logic [7:0]            host_addr, host_wdata, host_rdata, q;
  logic                  host_wr, host_rd, e1_custom_shape_enable;
  logic [GPS_NUM_CH-1:0] ch_e1_mode = 14'h2A5B;
  logic [GPS_NUM_CH-1:0] ch_custom_shape;
  int                    n_mismatch = 0;
  int                    tests_run = 0;

  always #10 clk = ~clk;

  gps_host host (.clk(clk), .host_rdata(host_rdata), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd));
  gps_regs #(.PART_ID(PID), .REVISION(REV)) dut (.clk(clk), .rst_n(rst_n),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .ch_e1_mode(ch_e1_mode), .host_rdata(host_rdata),
    .e1_custom_shape_enable(e1_custom_shape_enable), .ch_custom_shape(ch_custom_shape));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd_chk(input string n, input logic [7:0] a, e);
    host.xfer(1'h0, a, 8'h00, q);
    chk(n, {8'h00, q}, {8'h00, e});
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, d);
    host.xfer(1'h1, a, d, q);
  endtask : wr
  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // The shape select lags the enable by one cycle, hence the extra edge.
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    rd_chk("select", GPS_OFS_SHAPE_SEL, 8'h00);
    chk("shape", {2'h0, ch_custom_shape}, 16'h0000);
    wr(GPS_OFS_PART_ID, 8'h00);
    wr(GPS_OFS_REVISION, 8'hFF);
    rd_chk("id", GPS_OFS_PART_ID, PID);
    rd_chk("rev", GPS_OFS_REVISION, REV);
    $display("test reset and identity done");
    wr(GPS_OFS_SHAPE_SEL, 8'hFF);
    chk("enable", {15'h0, e1_custom_shape_enable}, 16'h0001);
    @(negedge clk);
    chk("shape", {2'h0, ch_custom_shape}, 16'h2A5B);
    rd_chk("select", GPS_OFS_SHAPE_SEL, 8'h01);
    ch_e1_mode = 14'h3FFF;
    @(negedge clk);
    chk("shape", {2'h0, ch_custom_shape}, 16'h3FFF);
    rd_chk("unmapped", 8'h10, 8'h00);
    wr(GPS_OFS_SHAPE_SEL, 8'hFE);
    chk("enable", {15'h0, e1_custom_shape_enable}, 16'h0000);
    @(negedge clk);
    chk("shape", {2'h0, ch_custom_shape}, 16'h0000);
    $display("test enable done");
    wr(GPS_OFS_SHAPE_SEL, 8'h01);
    rd_chk("id", GPS_OFS_PART_ID, PID);
    chk("shape", {2'h0, ch_custom_shape}, 16'h3FFF);
    rst_n = 1'h0;
    @(negedge clk);
    chk("enable", {15'h0, e1_custom_shape_enable}, 16'h0000);
    chk("shape", {2'h0, ch_custom_shape}, 16'h0000);
    chk("rdata", {8'h00, host_rdata}, 16'h0000);
    rst_n = 1'h1;
    rd_chk("select", GPS_OFS_SHAPE_SEL, 8'h00);
    $display("test mid-run reset done");
    close_out();
  end

  // Tests take about 31 cycles; a hang is cut at 2000.
  initial begin
    #40000;
    n_mismatch++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
